// file: dmacc_core.sv
// dma channel controller: channel table, attributes, enables, arbiter
// and a single transfer engine with a small read-to-write buffer
// assumes requests and memory bus are logic on clk_sys_i
`timescale 1ns/10ps

// plain valid/ready fifo, count based
module dmacc_fifo #(
  parameter int W = 32,
  parameter int D = 4
) (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  // fill side
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [W-1:0] in_data_i,
  // drain side
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [W-1:0] out_data_o
);
  localparam int AW = $clog2(D);
  logic [W-1:0] mem_r [D];     // storage
  logic [AW-1:0] wp_r, rp_r;   // pointers
  logic [AW:0] cnt_r;          // fill level
  logic push, pop;
  assign in_ready_o = (cnt_r != (AW+1)'(D));
  assign out_valid_o = (cnt_r != '0);
  assign out_data_o = mem_r[rp_r];
  assign push = in_valid_i & in_ready_o;
  assign pop = out_valid_o & out_ready_i;
  // pointers wrap at depth, which need not be a power of two
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      wp_r <= '0;
      rp_r <= '0;
      cnt_r <= '0;
    end else begin
      if (push) begin
        mem_r[wp_r] <= in_data_i;
        wp_r <= (wp_r == AW'(D-1)) ? '0 : wp_r + 1'b1;
      end
      if (pop) rp_r <= (rp_r == AW'(D-1)) ? '0 : rp_r + 1'b1;
      cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

module dmacc_core import dmacc_pkg::*; (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  // structure writes
  input wire logic cfg_ctl_wr_i,
  input wire logic cfg_xfer_wr_i,
  input wire logic [5:0] cfg_idx_i,
  input wire logic [CTL_W-1:0] cfg_ctl_i,
  input wire logic [2:0] cfg_mode_i,
  input wire logic [9:0] cfg_cnt_i,
  input wire logic [31:0] cfg_src_i,
  input wire logic [31:0] cfg_dst_i,
  // structure readback
  input wire logic [5:0] rb_idx_i,
  output logic [2:0] rb_mode_o,
  output logic [10:0] rb_cnt_o,
  // attributes
  input wire logic [4:0] attr_chan_i,
  input wire logic [3:0] attr_set_i,
  input wire logic [3:0] attr_clr_i,
  output logic [3:0] attr_rd_o,
  // enables
  input wire logic [NCH-1:0] en_set_i,
  input wire logic [NCH-1:0] en_clr_i,
  output logic [NCH-1:0] en_o,
  // channel map
  input wire logic map_wr_i,
  input wire logic [4:0] map_chan_i,
  input wire logic [4:0] map_sel_i,
  // requests
  input wire logic [NCH-1:0] periph_sreq_i,
  input wire logic [NCH-1:0] periph_breq_i,
  input wire logic [NCH-1:0] sw_req_i,
  // memory read
  output logic mem_rd_req_o,
  output logic [31:0] mem_rd_addr_o,
  output logic [1:0] mem_rd_size_o,
  input wire logic mem_rd_gnt_i,
  input wire logic mem_rd_valid_i,
  input wire logic [31:0] mem_rd_data_i,
  // memory write
  output logic mem_wr_req_o,
  output logic [31:0] mem_wr_addr_o,
  output logic [1:0] mem_wr_size_o,
  output logic [31:0] mem_wr_data_o,
  input wire logic mem_wr_gnt_i,
  // completion and status
  output logic ctl_done_o,
  output logic [NCH-1:0] periph_done_o,
  output logic busy_o
);
  // channel table, primary at 0-31, alternate at 32-63
  logic [CTL_W-1:0] ctl_m [NIDX];
  logic [2:0] mode_m [NIDX];
  logic [9:0] cnt_m [NIDX];
  logic [31:0] src_m [NIDX];
  logic [31:0] dst_m [NIDX];
  // per-channel state
  logic [3:0] attr_r [NCH];
  logic [4:0] map_r [NCH];
  logic [NCH-1:0] en_r, swp_r, run_r, sgt_r;
  logic [NCH-1:0] want, hw_s, hw_b;
  // engine
  dmacc_st_t st_r;
  logic [4:0] ch_r;              // active channel
  logic [5:0] idx_r;             // active structure
  logic [31:0] src_r, dst_r;
  logic [CTL_W-1:0] ctl_r;
  logic [2:0] mode_r;
  logic [10:0] rem_r, chunk_r, wl_r;
  logic rd_pend_r, sg_r, fin_r;
  logic [1:0] tw_r;              // task word number
  logic [31:0] tw0_r, tw1_r;
  // arbiter result
  logic pick_vld;
  logic [4:0] pick_ch;
  // load decode
  logic [5:0] ld_idx;
  logic [10:0] ld_rem, ld_arb;
  logic ld_burst;
  // fifo links
  logic f_in_rdy, f_out_vld, f_pop;
  logic [31:0] f_out_data;
  logic [NCH-1:0] fin_mask;

  // step in bytes for a step code, zero when fixed
  function automatic logic [31:0] step_of(input logic [1:0] code);
    step_of = (code == STEP_FIXED) ? 32'h0 : (32'h1 << code);
  endfunction

  // per-channel request qualification
  genvar g;
  generate
    for (g = 0; g < NCH; g++) begin : g_req
      assign hw_s[g] = periph_sreq_i[map_r[g]] & ~attr_r[g][AT_MASK]
                       & ~attr_r[g][AT_BURST];
      assign hw_b[g] = periph_breq_i[map_r[g]] & ~attr_r[g][AT_MASK];
      assign want[g] = en_r[g] & (hw_s[g] | hw_b[g] | swp_r[g]
                       | run_r[g]);
    end
  endgenerate

  // fixed priority: high-priority channels first, then lowest number
  always_comb begin
    pick_vld = 1'b0;
    pick_ch = '0;
    for (int c = NCH - 1; c >= 0; c--) begin
      if (want[c] & ~attr_r[c][AT_HIPRI]) begin
        pick_vld = 1'b1;
        pick_ch = 5'(c);
      end
    end
    for (int c = NCH - 1; c >= 0; c--) begin
      if (want[c] & attr_r[c][AT_HIPRI]) begin
        pick_vld = 1'b1;
        pick_ch = 5'(c);
      end
    end
  end

  // structure chosen at load: alternate by attribute or during a task
  assign ld_idx = {attr_r[ch_r][AT_ALT] | sgt_r[ch_r], ch_r};
  assign ld_rem = {1'b0, cnt_m[ld_idx]} + 11'h1;
  assign ld_arb = 11'h1 << ctl_m[ld_idx][CF_ARB +: 4];
  assign ld_burst = hw_b[ch_r] | swp_r[ch_r] | run_r[ch_r]
                    | (mode_m[ld_idx] == MD_AUTO);
  assign f_pop = f_out_vld & ~mem_wr_req_o & (st_r == E_RUN);
  assign fin_mask = (st_r == E_WB && fin_r) ? (NCH'(1) << ch_r) : '0;

  // transfer engine
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      st_r <= E_IDLE;
      ch_r <= '0;
      idx_r <= '0;
      src_r <= '0;
      dst_r <= '0;
      ctl_r <= '0;
      mode_r <= MD_STOP;
      rem_r <= '0;
      chunk_r <= '0;
      wl_r <= '0;
      rd_pend_r <= 1'b0;
      sg_r <= 1'b0;
      fin_r <= 1'b0;
      tw_r <= '0;
      tw0_r <= '0;
      tw1_r <= '0;
      mem_rd_req_o <= 1'b0;
      mem_rd_addr_o <= '0;
      mem_rd_size_o <= SZ_8;
    end else begin
      unique case (st_r)
        E_IDLE: begin
          if (pick_vld) begin
            ch_r <= pick_ch;
            st_r <= E_LOAD;
          end
        end
        E_LOAD: begin
          idx_r <= ld_idx;
          src_r <= src_m[ld_idx];
          dst_r <= dst_m[ld_idx];
          ctl_r <= ctl_m[ld_idx];
          mode_r <= mode_m[ld_idx];
          rem_r <= ld_rem;
          sg_r <= sgt_r[ch_r];
          tw_r <= '0;
          if (mode_m[ld_idx] == MD_STOP) begin
            st_r <= E_IDLE;
          end else if (!ld_idx[ALT_BIT] && (mode_m[ld_idx] == MD_MEM_SG ||
                       mode_m[ld_idx] == MD_PER_SG)) begin
            st_r <= E_TASK;
          end else if (!ld_burst && ctl_m[ld_idx][CF_TAIL] && sgt_r[ch_r]
                       && ld_rem <= ld_arb) begin
            st_r <= E_IDLE;
          end else begin
            chunk_r <= !ld_burst ? 11'h1 :
                       (ld_rem < ld_arb ? ld_rem : ld_arb);
            wl_r <= !ld_burst ? 11'h1 :
                    (ld_rem < ld_arb ? ld_rem : ld_arb);
            st_r <= E_RUN;
          end
        end
        E_TASK: begin
          // fetch three words of the next task from primary source
          if (!mem_rd_req_o && !rd_pend_r) begin
            mem_rd_req_o <= 1'b1;
            mem_rd_addr_o <= src_r + {28'h0, tw_r, 2'h0};
            mem_rd_size_o <= SZ_32;
          end
          if (mem_rd_req_o && mem_rd_gnt_i) begin
            mem_rd_req_o <= 1'b0;
            rd_pend_r <= 1'b1;
          end
          if (rd_pend_r && mem_rd_valid_i) begin
            rd_pend_r <= 1'b0;
            tw_r <= tw_r + 2'h1;
            if (tw_r == '0) tw0_r <= mem_rd_data_i;
            if (tw_r == 2'h1) tw1_r <= mem_rd_data_i;
            if (tw_r == TASK_LAST) st_r <= E_LOAD;
          end
        end
        E_RUN: begin
          // one read outstanding; only issued while the buffer has room
          if (!mem_rd_req_o && !rd_pend_r && chunk_r != '0 && f_in_rdy) begin
            mem_rd_req_o <= 1'b1;
            mem_rd_addr_o <= src_r;
            mem_rd_size_o <= ctl_r[CF_SIZE +: 2];
          end
          if (mem_rd_req_o && mem_rd_gnt_i) begin
            mem_rd_req_o <= 1'b0;
            rd_pend_r <= 1'b1;
            src_r <= src_r + step_of(ctl_r[CF_SINC +: 2]);
            chunk_r <= chunk_r - 11'h1;
            rem_r <= rem_r - 11'h1;
          end
          if (rd_pend_r && mem_rd_valid_i) rd_pend_r <= 1'b0;
          if (mem_wr_req_o && mem_wr_gnt_i) wl_r <= wl_r - 11'h1;
          if (f_pop) dst_r <= dst_r + step_of(ctl_r[CF_DINC +: 2]);
          if (chunk_r == '0 && wl_r == '0) begin
            fin_r <= (rem_r == '0);
            st_r <= E_WB;
          end
        end
        E_WB: st_r <= E_IDLE;
      endcase
    end
  end

  // writer side drains the buffer into destination memory
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      mem_wr_req_o <= 1'b0;
      mem_wr_addr_o <= '0;
      mem_wr_size_o <= SZ_8;
      mem_wr_data_o <= '0;
    end else if (f_pop) begin
      mem_wr_req_o <= 1'b1;
      mem_wr_addr_o <= dst_r;
      mem_wr_size_o <= ctl_r[CF_SIZE +: 2];
      mem_wr_data_o <= f_out_data;
    end else if (mem_wr_gnt_i) begin
      mem_wr_req_o <= 1'b0;
    end
  end

  dmacc_fifo #(.W(32), .D(FIFO_D)) u_fifo (
    .clk_sys_i(clk_sys_i),
    .sys_rst_i(sys_rst_i),
    .in_valid_i(mem_rd_valid_i & rd_pend_r & (st_r == E_RUN)),
    .in_ready_o(f_in_rdy),
    .in_data_i(mem_rd_data_i),
    .out_valid_o(f_out_vld),
    .out_ready_i(f_pop),
    .out_data_o(f_out_data)
  );

  // channel table: software writes, task copies and write-back
  // engine updates come last so they win over a racing software write
  always_ff @(posedge clk_sys_i) begin
    if (cfg_ctl_wr_i) ctl_m[cfg_idx_i] <= cfg_ctl_i;
    if (cfg_xfer_wr_i) begin
      mode_m[cfg_idx_i] <= cfg_mode_i;
      cnt_m[cfg_idx_i] <= cfg_cnt_i;
      src_m[cfg_idx_i] <= cfg_src_i;
      dst_m[cfg_idx_i] <= cfg_dst_i;
    end
    if (st_r == E_TASK && rd_pend_r && mem_rd_valid_i
        && tw_r == TASK_LAST) begin
      src_m[{1'b1, ch_r}] <= tw0_r;
      dst_m[{1'b1, ch_r}] <= tw1_r;
      ctl_m[{1'b1, ch_r}] <= mem_rd_data_i[CTL_W-1:0];
      mode_m[{1'b1, ch_r}] <= mem_rd_data_i[TW_MODE +: 3];
      cnt_m[{1'b1, ch_r}] <= mem_rd_data_i[TW_CNT +: 10];
      src_m[idx_r] <= src_r + TASK_BYTES;
      cnt_m[idx_r] <= cnt_m[idx_r] - 10'h1;
      if (cnt_m[idx_r] == '0) mode_m[idx_r] <= MD_STOP;
    end
    if (st_r == E_WB) begin
      src_m[idx_r] <= src_r;
      dst_m[idx_r] <= dst_r;
      cnt_m[idx_r] <= fin_r ? '0 : 10'(rem_r - 11'h1);
      if (fin_r) mode_m[idx_r] <= MD_STOP;
    end
  end

  // task in progress: set after a fetch, cleared when the task ends
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      sgt_r <= '0;
    end else if (st_r == E_TASK && rd_pend_r && mem_rd_valid_i
                 && tw_r == TASK_LAST) begin
      sgt_r[ch_r] <= 1'b1;
    end else if (st_r == E_WB && fin_r) begin
      sgt_r[ch_r] <= 1'b0;
    end
  end

  // enables: software set wins over completion and software clear
  // a task chain keeps the channel enabled until its last task
  logic last_fin;
  assign last_fin = ~(sg_r && (mode_r == MD_MEM_SG || mode_r == MD_PER_SG)
                    && mode_m[{1'b0, ch_r}] != MD_STOP);
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      en_r <= '0;
      swp_r <= '0;
      run_r <= '0;
    end else begin
      en_r <= (en_r & ~en_clr_i & ~(last_fin ? fin_mask : '0))
              | en_set_i;
      swp_r <= (swp_r & ~((st_r == E_LOAD) ? (NCH'(1) << ch_r) : '0))
               | sw_req_i;
      if (st_r == E_LOAD && (mode_m[ld_idx] == MD_AUTO ||
          mode_m[ld_idx] == MD_MEM_SG))
        run_r[ch_r] <= 1'b1;
      else if (st_r == E_WB && fin_r && last_fin)
        run_r[ch_r] <= 1'b0;
      else
        run_r <= run_r & en_r;
    end
  end

  // attributes and map, each channel set and cleared on its own
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      for (int c = 0; c < NCH; c++) begin
        attr_r[c] <= '0;
        map_r[c] <= 5'(c);
      end
    end else begin
      attr_r[attr_chan_i] <= (attr_r[attr_chan_i] & ~attr_clr_i)
                             | attr_set_i;
      if (map_wr_i) map_r[map_chan_i] <= map_sel_i;
    end
  end

  // readback and completion outputs, all registered
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      rb_mode_o <= MD_STOP;
      rb_cnt_o <= '0;
      attr_rd_o <= '0;
      en_o <= '0;
      ctl_done_o <= 1'b0;
      periph_done_o <= '0;
      busy_o <= 1'b0;
    end else begin
      rb_mode_o <= mode_m[rb_idx_i];
      rb_cnt_o <= (mode_m[rb_idx_i] == MD_STOP) ? '0
                  : {1'b0, cnt_m[rb_idx_i]} + 11'h1;
      attr_rd_o <= attr_r[attr_chan_i];
      en_o <= en_r;
      ctl_done_o <= (st_r == E_WB) && fin_r && last_fin
                    && ch_r == SW_CHAN;
      periph_done_o <= (ch_r == SW_CHAN || !last_fin) ? '0 : fin_mask;
      busy_o <= (st_r != E_IDLE);
    end
  end

  // checks
  a_done_clears_en: assert property (@(posedge clk_sys_i)
    disable iff (sys_rst_i) (st_r == E_WB && fin_r && last_fin
    && !en_set_i[ch_r]) |=> !en_r[$past(ch_r)])
    else $error("enable not cleared on completion");
  a_stop_written: assert property (@(posedge clk_sys_i)
    disable iff (sys_rst_i) (st_r == E_WB && fin_r) |=>
    mode_m[$past(idx_r)] == MD_STOP) else $error("stop mode not written");
  a_src_stepping: assert property (@(posedge clk_sys_i)
    disable iff (sys_rst_i) (st_r == E_RUN && mem_rd_req_o && mem_rd_gnt_i)
    |=> src_r == $past(src_r) + step_of($past(ctl_r[CF_SINC +: 2])))
    else $error("source step wrong");
  a_dst_stepping: assert property (@(posedge clk_sys_i)
    disable iff (sys_rst_i) f_pop |=> mem_wr_addr_o + step_of(ctl_r[
    CF_DINC +: 2]) == dst_r) else $error("destination step wrong");
  a_chunk_bound: assert property (@(posedge clk_sys_i)
    disable iff (sys_rst_i) (st_r == E_RUN) |->
    chunk_r <= (11'h1 << ctl_r[CF_ARB +: 4])) else $error("chunk too big");
  a_only_enabled: assert property (@(posedge clk_sys_i)
    disable iff (sys_rst_i) (st_r == E_IDLE && pick_vld) |-> en_r[pick_ch])
    else $error("disabled channel picked");
  a_mask_blocks: assert property (@(posedge clk_sys_i)
    disable iff (sys_rst_i) attr_r[pick_ch][AT_MASK] |->
    !hw_s[pick_ch] && !hw_b[pick_ch]) else $error("masked request seen");
  a_sw_irq_only: assert property (@(posedge clk_sys_i)
    disable iff (sys_rst_i) ctl_done_o |-> $past(ch_r) == SW_CHAN &&
    periph_done_o == '0) else $error("wrong completion line");
  a_size_legal: assert property (@(posedge clk_sys_i)
    disable iff (sys_rst_i) (mem_rd_req_o && st_r == E_RUN) |->
    mem_rd_size_o != 2'h3) else $error("illegal item size");
  // completion of a peripheral channel, seen at its write-back cycle
  sequence s_periph_fin;
    st_r == E_WB && fin_r && last_fin && ch_r != SW_CHAN;
  endsequence
  a_periph_done: assert property (@(posedge clk_sys_i)
    disable iff (sys_rst_i) s_periph_fin |=> periph_done_o[$past(ch_r)])
    else $error("peripheral completion missing");
endmodule

// file: dmacc_pkg.sv
// constants, encodings and table layout for the dma channel controller
// assumes one 10 mhz system clock and a word-wide memory bus on same clock
package dmacc_pkg;
  localparam int NCH = 32;          // channel count
  localparam int NIDX = 64;         // primary plus alternate structures
  localparam int ALT_BIT = 5;       // index bit marking the alternate half
  localparam int CTL_W = 11;        // control word width
  localparam int FIFO_D = 4;        // words buffered between read and write
  // control word fields
  localparam int CF_SIZE = 0;       // item size, 2 bits
  localparam int CF_SINC = 2;       // source step, 2 bits
  localparam int CF_DINC = 4;       // destination step, 2 bits
  localparam int CF_ARB = 6;        // log2 of arbitration size, 4 bits
  localparam int CF_TAIL = 10;      // burst_at_tail_flag
  // item size and step codes
  localparam logic [1:0] SZ_8 = 2'h0;
  localparam logic [1:0] SZ_16 = 2'h1;
  localparam logic [1:0] SZ_32 = 2'h2;
  localparam logic [1:0] STEP_FIXED = 2'h3; // source/destination_step_fixed
  localparam logic [3:0] ARB_MAX = 4'ha;    // arbitration_size_max, 1024
  // mode codes
  localparam logic [2:0] MD_STOP = 3'h0;
  localparam logic [2:0] MD_BASIC = 3'h1;
  localparam logic [2:0] MD_AUTO = 3'h2;
  localparam logic [2:0] MD_PINGPONG = 3'h3;
  localparam logic [2:0] MD_MEM_SG = 3'h4;
  localparam logic [2:0] MD_PER_SG = 3'h5;  // peripheral_gather_mode
  // attribute bits
  localparam int AT_BURST = 0;      // burst_only_attribute
  localparam int AT_ALT = 1;        // alternate_structure_attribute
  localparam int AT_HIPRI = 2;      // high priority
  localparam int AT_MASK = 3;       // request_mask_attribute
  // task entry third word: control, mode and count-1
  localparam int TW_MODE = 11;
  localparam int TW_CNT = 14;
  localparam logic [31:0] TASK_BYTES = 32'hc; // three words per task
  localparam logic [1:0] TASK_LAST = 2'h2;
  localparam logic [4:0] SW_CHAN = 5'h1e;     // software_channel
  typedef enum {E_IDLE, E_LOAD, E_TASK, E_RUN, E_WB} dmacc_st_t;
endpackage

// file: dmacc_mem.sv
// memory partner: word store with grant and read data a cycle later
// assumes word-wide items and engine requests held until granted
`timescale 1ns/10ps
module dmacc_mem (
  // clock, reset and pacing
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  input wire logic slow_i,
  // read side
  input wire logic rd_req_i,
  input wire logic [31:0] rd_addr_i,
  output logic rd_gnt_o,
  output logic rd_valid_o,
  output logic [31:0] rd_data_o,
  // write side
  input wire logic wr_req_i,
  input wire logic [31:0] wr_addr_i,
  input wire logic [31:0] wr_data_i,
  output logic wr_gnt_o
);
  logic [31:0] mem [256]; // words, indexed by address bits 9:2
  logic ph_r; // toggles so slow grants come every other cycle
  // one grant per request; a slow bus makes the engine wait
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      ph_r <= 1'b0;
      rd_gnt_o <= 1'b0;
      wr_gnt_o <= 1'b0;
      rd_valid_o <= 1'b0;
    end else begin
      ph_r <= ~ph_r;
      rd_gnt_o <= rd_req_i && !rd_gnt_o && (ph_r || !slow_i);
      wr_gnt_o <= wr_req_i && !wr_gnt_o && (ph_r || !slow_i);
      rd_valid_o <= rd_gnt_o;
    end
  end
  // data only valid for one cycle, otherwise the bus shows junk
  // plain always so the bench may preload the store and task lists
  always @(posedge clk_sys_i) begin
    if (rd_gnt_o) begin
      rd_data_o <= mem[rd_addr_i[9:2]];
    end else begin
      rd_data_o <= ~rd_data_o;
    end
    if (wr_gnt_o && wr_req_i) begin
      mem[wr_addr_i[9:2]] <= wr_data_i;
    end
  end
endmodule

// file: dma_channel_config_control_bench.sv
// self-checking bench for the dma channel controller core
// assumes the memory partner; words only, steps never below item size except a fixed source step
`timescale 1ns/10ps
module dma_channel_config_control_bench import dmacc_pkg::*;;
  logic clk_sys_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic cfg_ctl_wr_i, cfg_xfer_wr_i, map_wr_i, slow;
  logic [5:0] cfg_idx_i, rb_idx_i;
  logic [CTL_W-1:0] cfg_ctl_i;
  logic [2:0] cfg_mode_i, rb_mode_o;
  logic [9:0] cfg_cnt_i;
  logic [10:0] rb_cnt_o;
  logic [31:0] cfg_src_i, cfg_dst_i;
  logic [4:0] attr_chan_i, map_chan_i, map_sel_i;
  logic [3:0] attr_set_i, attr_clr_i, attr_rd_o;
  logic [NCH-1:0] en_set_i, en_clr_i, en_o, periph_done_o;
  logic [NCH-1:0] periph_sreq_i, periph_breq_i, sw_req_i;
  logic mem_rd_req_o, mem_rd_gnt_i, mem_rd_valid_i;
  logic mem_wr_req_o, mem_wr_gnt_i, ctl_done_o, busy_o;
  logic [31:0] mem_rd_addr_o, mem_rd_data_i, mem_wr_addr_o, mem_wr_data_o;
  int errors = 0; // mismatches seen
  int n_checks = 0; // comparisons made
  // device under test
  dmacc_core u_dmacc_core (.clk_sys_i, .sys_rst_i, .cfg_ctl_wr_i,
    .cfg_xfer_wr_i, .cfg_idx_i, .cfg_ctl_i, .cfg_mode_i, .cfg_cnt_i,
    .cfg_src_i, .cfg_dst_i, .rb_idx_i, .rb_mode_o, .rb_cnt_o, .attr_chan_i,
    .attr_set_i, .attr_clr_i, .attr_rd_o, .en_set_i, .en_clr_i, .en_o,
    .map_wr_i, .map_chan_i, .map_sel_i, .periph_sreq_i, .periph_breq_i,
    .sw_req_i, .mem_rd_req_o, .mem_rd_addr_o, .mem_rd_size_o(),
    .mem_rd_gnt_i, .mem_rd_valid_i, .mem_rd_data_i, .mem_wr_req_o,
    .mem_wr_addr_o, .mem_wr_size_o(), .mem_wr_data_o, .mem_wr_gnt_i,
    .ctl_done_o, .periph_done_o, .busy_o);
  // memory on the far side
  dmacc_mem u_dmacc_mem (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i),
    .slow_i(slow), .rd_req_i(mem_rd_req_o), .rd_addr_i(mem_rd_addr_o),
    .rd_gnt_o(mem_rd_gnt_i), .rd_valid_o(mem_rd_valid_i),
    .rd_data_o(mem_rd_data_i), .wr_req_i(mem_wr_req_o),
    .wr_addr_i(mem_wr_addr_o), .wr_data_i(mem_wr_data_o),
    .wr_gnt_o(mem_wr_gnt_i));
  // 100 ns period
  always #50 clk_sys_i = ~clk_sys_i;
  // inputs always change just after the rising edge
  task automatic tick();
    @(posedge clk_sys_i);
    #1;
  endtask
  // verdict and end of run
  task automatic results();
    $display("checks %0d mismatches %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // compare with case equality so unknowns never match
  task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      errors++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  // write both halves of one structure in the same cycle
  task automatic wr_struct(logic [5:0] ix, logic [10:0] c, logic [2:0] m,
    logic [9:0] n, logic [31:0] s, logic [31:0] d);
    cfg_idx_i = ix;
    cfg_ctl_i = c;
    cfg_mode_i = m;
    cfg_cnt_i = n;
    cfg_src_i = s;
    cfg_dst_i = d;
    cfg_ctl_wr_i = 1'b1;
    cfg_xfer_wr_i = 1'b1;
    tick();
    cfg_ctl_wr_i = 1'b0;
    cfg_xfer_wr_i = 1'b0;
  endtask
  // one-cycle attribute set and clear on a channel
  task automatic attr(logic [4:0] c, logic [3:0] s, logic [3:0] k);
    attr_chan_i = c;
    attr_set_i = s;
    attr_clr_i = k;
    tick();
    attr_set_i = 4'h0;
    attr_clr_i = 4'h0;
    tick();
  endtask
  // wait for the done pulse of a channel, bounded
  task automatic wait_done(int ch);
    int k;
    for (k = 0; k < 800; k++) begin
      tick();
      if (ch == 30 ? ctl_done_o === 1'b1 : periph_done_o[ch] === 1'b1) break;
    end
    if (k == 800) begin
      errors++;
      $display("mismatch done expected 1 seen 0");
      results();
    end
  endtask
  // engine must stay idle for n cycles
  task automatic idle(int n);
    int b;
    b = 0;
    repeat (n) begin
      tick();
      b += (busy_o !== 1'b0);
    end
    chk("busy", 0, b);
  endtask
  // software channel in a given mode, then status and enable checks
  task automatic run_sw(logic [10:0] c, logic [2:0] m, logic [9:0] n,
    logic [31:0] s, logic [31:0] d);
    wr_struct(6'h1e, c, m, n, s, d);
    en_set_i[30] = 1'b1;
    sw_req_i[30] = 1'b1;
    tick();
    en_set_i = '0;
    sw_req_i = '0;
    wait_done(30);
    rb_idx_i = 6'h1e;
    tick();
    chk("mode", {29'h0, MD_STOP}, {29'h0, rb_mode_o});
    chk("count", 0, {21'h0, rb_cnt_o});
    chk("enable", 0, {31'h0, en_o[30]});
  endtask
  initial begin
    {cfg_ctl_wr_i, cfg_xfer_wr_i, map_wr_i, slow} = '0;
    {cfg_idx_i, rb_idx_i, cfg_ctl_i, cfg_mode_i, cfg_cnt_i} = '0;
    {cfg_src_i, cfg_dst_i, attr_chan_i, map_chan_i, map_sel_i} = '0;
    {attr_set_i, attr_clr_i, en_set_i, en_clr_i} = '0;
    {periph_sreq_i, periph_breq_i, sw_req_i} = '0;
    for (int i = 0; i < 256; i++) u_dmacc_mem.mem[i] = {24'ha50000, i[7:0]};
    repeat (16) tick();
    sys_rst_i = 1'b0;
    tick();
    chk("enables", 0, en_o);
    chk("attributes", 0, {28'h0, attr_rd_o});
    // every attribute sets and clears alone
    for (int b = 0; b < 4; b++) begin
      attr(5'h05, 4'h1 << b, 4'h0);
      chk("attr set", 32'h1 << b, {28'h0, attr_rd_o});
      attr(5'h05, 4'h0, 4'h1 << b);
      chk("attr clr", 0, {28'h0, attr_rd_o});
    end
    $display("test attributes done");
    // four words, chunks of two, slow memory
    slow = 1'b1;
    run_sw({1'b0, 4'h1, 2'h2, 2'h2, SZ_32}, MD_AUTO, 10'h3, 32'h100,
      32'h200);
    for (int j = 0; j < 4; j++)
      chk("copy", {24'ha50000, 8'h40 + 8'(j)}, u_dmacc_mem.mem[8'h80 + j]);
    $display("test auto copy done");
    // fixed source repeats the same word
    slow = 1'b0;
    run_sw({1'b0, 4'h1, 2'h2, STEP_FIXED, SZ_32}, MD_AUTO, 10'h1, 32'h100,
      32'h300);
    for (int j = 0; j < 2; j++)
      chk("fixed", 32'ha5000040, u_dmacc_mem.mem[8'hc0 + j]);
    $display("test fixed source done");
    // two-task chain listed at 0x3c0, the last task in auto mode
    u_dmacc_mem.mem[8'hf0] = 32'h100;
    u_dmacc_mem.mem[8'hf1] = 32'h240;
    u_dmacc_mem.mem[8'hf2] = {8'h0, 10'h1, MD_MEM_SG, 1'b0, 4'h1, 2'h2,
      2'h2, SZ_32};
    u_dmacc_mem.mem[8'hf3] = 32'h120;
    u_dmacc_mem.mem[8'hf4] = 32'h280;
    u_dmacc_mem.mem[8'hf5] = {8'h0, 10'h0, MD_AUTO, 1'b0, 4'h1, 2'h2,
      2'h2, SZ_32};
    run_sw({1'b0, 4'h1, 2'h2, 2'h2, SZ_32}, MD_MEM_SG, 10'h1, 32'h3c0,
      32'h0);
    rb_idx_i = 6'h3e;
    tick();
    chk("alt mode", {29'h0, MD_STOP}, {29'h0, rb_mode_o});
    for (int j = 0; j < 2; j++)
      chk("task one", {24'ha50000, 8'h40 + 8'(j)},
        u_dmacc_mem.mem[8'h90 + j]);
    chk("task two", 32'ha5000048, u_dmacc_mem.mem[8'ha0]);
    $display("test task chain done");
    // channel 3 fed from request line 7, basic, one word
    wr_struct(6'h03, {1'b0, 4'h0, 2'h2, 2'h2, SZ_32}, MD_BASIC, 10'h0,
      32'h110, 32'h380);
    map_wr_i = 1'b1;
    map_chan_i = 5'h03;
    map_sel_i = 5'h07;
    en_set_i[3] = 1'b1;
    tick();
    map_wr_i = 1'b0;
    en_set_i = '0;
    en_clr_i[3] = 1'b1;
    tick();
    en_clr_i = '0;
    periph_sreq_i[7] = 1'b1;
    idle(20);
    attr(5'h03, 4'h8, 4'h0);
    en_set_i[3] = 1'b1;
    tick();
    en_set_i = '0;
    idle(20);
    attr(5'h03, 4'h1, 4'h8);
    idle(20);
    periph_breq_i[7] = 1'b1;
    wait_done(3);
    periph_sreq_i = '0;
    periph_breq_i = '0;
    tick();
    chk("enable", 0, {31'h0, en_o[3]});
    chk("word", 32'ha5000044, u_dmacc_mem.mem[8'he0]);
    $display("test peripheral channel done");
    results();
  end
endmodule
